// ---- lcc_params.svh ----
// constants of the logic cell cluster counter: offsets, fields, resets
// assumes a 12-bit APB byte address and 32-bit data words
`ifndef LCC_PARAMS_SVH
`define LCC_PARAMS_SVH

`define LCC_NUM_CELLS 10
`define LCC_NUM_GNETS 4

`define LCC_ENABLE_OFS 12'h000
`define LCC_DIR_OFS 12'h004
`define LCC_LDATA_OFS 12'h008
`define LCC_CTRL_OFS 12'h00c
`define LCC_COUNT_OFS 12'h010
`define LCC_GNET_OFS 12'h014
`define LCC_MEMBER_OFS 12'h018

`define LCC_CTRL_SCLR 0
`define LCC_CTRL_SLOAD 1
`define LCC_CTRL_CASC 2
`define LCC_COUNT_CARRY 31
`define LCC_GNET_SRC_LSB 0
`define LCC_GNET_DRV_LSB 4
`define LCC_GNET_ACSEL_LSB 8
`define LCC_GNET_ACEN 10
`define LCC_GNET_LVL_LSB 16

`define LCC_ENABLE_RST 32'hffff_ffff
`define LCC_DIR_RST 32'h0000_0000
`define LCC_LDATA_RST 32'h0000_0000
`define LCC_MEMBER_RST 32'hffff_ffff
`define LCC_GNET_RST 32'h0000_0000

`endif

// ---- lcc_pkg.sv ----
// shared types of the logic cell cluster counter
// assumes a 32-bit register bus and a 12-bit register address
package lcc_pkg;
    typedef logic [31:0] lcc_word_t;
    typedef logic [11:0] lcc_addr_t;
endpackage

// ---- lcc_ctl_if.sv ----
// cluster-wide and per-cell controls and cell state between the top and the cell bank
// assumes one driver, the cluster top, for every control signal
interface lcc_ctl_if #(parameter int CW = 9);
    logic          sclr;
    logic          sload;
    logic          casc_en;
    logic          aclr;
    logic [CW-1:0] en;
    logic [CW-1:0] dn;
    logic [CW-1:0] member;
    logic [CW-1:0] ldata;
    logic [CW-1:0] casc_in;
    logic [CW-1:0] q;
    logic          carry;

    modport ctl (output sclr, sload, casc_en, aclr, en, dn, member,
                 output ldata, casc_in, input q, carry);
    modport cells (input sclr, sload, casc_en, aclr, en, dn, member,
                   input ldata, casc_in, output q, carry);
endinterface

// ---- lcc_cells.sv ----
// bank of counter cells: lookups, carry chain, load selector, clear gate
// assumes aclr comes from a flip-flop, so it is glitch free
module lcc_cells
    import lcc_pkg::*;
#(
    parameter int CW = 9
)
(
    // clock and reset
    input wire logic  clk,
    input wire logic  srst,
    // cluster controls and cell state
    lcc_ctl_if.cells  c
);

    logic [CW:0]   chain;
    logic [CW-1:0] cnt_d;
    logic [CW-1:0] casc_d;
    logic [CW-1:0] ld_d;
    logic [CW-1:0] q_next;
    logic [CW-1:0] q_reg;

    function automatic logic lut_data(input logic q, input logic ci,
                                      input logic en);
        return q ^ (ci & en);
    endfunction

    function automatic logic lut_carry(input logic q, input logic ci,
                                       input logic dn);
        return ci & (q ^ dn);
    endfunction

    // chain opens at the lowest counter bit
    assign chain[0] = 1'b1;

    for (genvar i = 0; i < CW; i++)
    begin : g_cell
        // carry feeds lookup and next stage
        assign cnt_d[i]   = lut_data(c.q[i], chain[i], c.en[i]);
        assign chain[i+1] = lut_carry(c.q[i], chain[i], c.dn[i]);
    end

    assign casc_d = c.casc_en ? (cnt_d & c.casc_in) : cnt_d;
    assign ld_d   = c.sload ? c.ldata : casc_d;
    // clear gate after the load selector
    assign q_next = ld_d & {CW{~c.sclr}} & c.member;

    always_ff @(posedge clk or posedge c.aclr)
    begin
        if (c.aclr)
            q_reg <= '0;
        else if (srst)
            q_reg <= '0;
        else
            q_reg <= q_next;
    end

    assign c.q     = q_reg;
    assign c.carry = chain[CW];

    default clocking @(posedge clk); endclocking
    default disable iff (srst || c.aclr);

    wire idle = !c.sclr && !c.sload && !c.casc_en && (&c.member);

    clear_wins_a: assert property (c.sclr |=> c.q == '0)
        else $error("clear did not zero the counter");
    load_value_a: assert property (
        c.sload && !c.sclr |=> c.q == $past(c.ldata & c.member))
        else $error("load value not taken");
    count_up_a: assert property (
        idle && (&c.en) && c.dn == '0 |=> c.q == CW'($past(c.q) + 1'b1))
        else $error("up count wrong");
    count_down_a: assert property (
        idle && (&c.en) && (&c.dn) |=> c.q == CW'($past(c.q) - 1'b1))
        else $error("down count wrong");
    count_hold_a: assert property (
        idle && c.en == '0 |=> $stable(c.q))
        else $error("disabled counter moved");
    no_stray_reg_a: assert property (
        1'b1 |=> (c.q & ~$past(c.member)) == '0)
        else $error("non-member cell holds a value");
    async_clear_a: assert property (
        @(posedge clk) disable iff (srst) c.aclr |-> c.q == '0)
        else $error("async clear not effective");

    wrap_up_c: cover property (idle && (&c.en) && (&c.q) && c.dn == '0);
    clr_load_c: cover property (c.sclr && c.sload);
    casc_load_c: cover property (c.casc_en && c.sload);
endmodule

// ---- lcc_gnet.sv ----
// global control nets: dedicated pin or cell-driven source per net
// assumes pins are asynchronous to the clock
module lcc_gnet
    import lcc_pkg::*;
#(
    parameter int NG = 4
)
(
    // clock and reset
    input wire logic           clk,
    input wire logic           srst,
    // dedicated pins and cell drive
    input wire logic [NG-1:0]  pin_raw,
    input wire logic [NG-1:0]  src_cell,
    input wire logic [NG-1:0]  cell_drv,
    // resolved net levels
    output logic     [NG-1:0]  level
);

    logic [NG-1:0] sync1_reg;
    logic [NG-1:0] sync2_reg;
    logic [NG-1:0] level_reg;

    // a cell-driven net ignores its pin
    wire [NG-1:0] level_next = (src_cell & cell_drv)
                             | (~src_cell & sync2_reg);

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            level_reg <= '0;
        end
        else
        begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
            level_reg <= level_next;
        end
    end

    assign level = level_reg;

    pin_blocked_a: assert property (
        @(posedge clk) disable iff (srst)
        src_cell != '0 |=> (level & $past(src_cell))
                           == ($past(cell_drv) & $past(src_cell)))
        else $error("cell-driven net followed its pin");
endmodule

// ---- lcc_counter.sv ----
// logic cell cluster in counter mode, with APB register access
// assumes one clock CLK, APB master on the same clock, async pins
// How it works
// - per-cell enable and direction controls
// - clear and load shared cluster-wide
// - cells are counter bits or combinational
// - two 3-input lookups per cell
// - load by selector, clear by AND
// - clear or load beats cascade
// - clear beats load
// - four dedicated global control nets
// - cell-driven net blocks its pin
// - first cell makes controls, not carry
// - carry feeds next bit forward
//
// The implementer's own choices: the register offsets and the APB register port.
`include "lcc_params.svh"

module lcc_counter
    import lcc_pkg::*;
#(
    parameter int CELLS = `LCC_NUM_CELLS,
    parameter int NG    = `LCC_NUM_GNETS
)
(
    // clock and reset
    input wire logic           CLK,
    input wire logic           SRST,
    // apb slave
    input wire logic           PSEL,
    input wire logic           PENABLE,
    input wire logic           PWRITE,
    input wire lcc_addr_t      PADDR,
    input wire lcc_word_t      PWDATA,
    output lcc_word_t          PRDATA,
    output logic               PREADY,
    output logic               PSLVERR,
    // first-cell control inputs
    input wire logic           CTL_CLR_IN,
    input wire logic           CTL_LOAD_IN,
    // cascade inputs, one per counter bit
    input wire logic [CELLS-2:0] CASC_IN,
    // dedicated global control pins
    input wire logic [NG-1:0]  GCTL_PIN,
    // counter state
    output logic [CELLS-2:0]   COUNT_OUT,
    output logic               CARRY_OUT,
    output logic [NG-1:0]      GNET_OUT
);

    // cell 0 is the control cell, so the counter is one bit shorter
    localparam int CW = CELLS - 1;

    if (CELLS < 2 || CELLS > 32)
    begin : g_cells_chk
        $error("CELLS must lie between 2 and 32");
    end
    if (NG != 4)
    begin : g_ng_chk
        $error("exactly four global nets are supported");
    end

    lcc_ctl_if #(.CW(CW)) c ();

    // registers
    logic [CW-1:0] en_reg;
    logic [CW-1:0] dir_reg;
    logic [CW-1:0] ldata_reg;
    logic [CW-1:0] member_reg;
    logic          casc_reg;
    logic [NG-1:0] gsrc_reg;
    logic [NG-1:0] gdrv_reg;
    logic [1:0]    acsel_reg;
    logic          acen_reg;
    logic          sclr_pulse_reg;
    logic          sload_pulse_reg;
    logic          aclr_reg;
    logic          pready_reg;
    logic          pslverr_reg;
    lcc_word_t     prdata_reg;
    logic          carry_reg;
    // pin synchronisers
    logic [CW+1:0] pin_s1_reg;
    logic [CW+1:0] pin_s2_reg;
    logic [NG-1:0] gnet_level;

    // apb decode
    wire access   = PSEL && PENABLE && !pready_reg;
    wire wr_fire  = PSEL && PENABLE && pready_reg && PWRITE;
    wire hit_en   = PADDR == `LCC_ENABLE_OFS;
    wire hit_dir  = PADDR == `LCC_DIR_OFS;
    wire hit_ld   = PADDR == `LCC_LDATA_OFS;
    wire hit_ctrl = PADDR == `LCC_CTRL_OFS;
    wire hit_cnt  = PADDR == `LCC_COUNT_OFS;
    wire hit_gnet = PADDR == `LCC_GNET_OFS;
    wire hit_mem  = PADDR == `LCC_MEMBER_OFS;
    wire mapped   = hit_en | hit_dir | hit_ld | hit_ctrl | hit_cnt
                  | hit_gnet | hit_mem;
    // the count is read only; a write to it is refused
    wire bad      = !mapped || (hit_cnt && PWRITE);
    wire wr_ok    = wr_fire && !pslverr_reg;

    // read data words
    wire lcc_word_t rd_en   = {{(32-CW){1'b0}}, en_reg};
    wire lcc_word_t rd_dir  = {{(32-CW){1'b0}}, dir_reg};
    wire lcc_word_t rd_ld   = {{(32-CW){1'b0}}, ldata_reg};
    wire lcc_word_t rd_mem  = {{(32-CW){1'b0}}, member_reg};
    wire lcc_word_t rd_ctrl = {29'h0000_0000, casc_reg, 2'h0};
    wire lcc_word_t rd_cnt  = ({{(32-CW){1'b0}}, c.q})
                            | ({31'h0000_0000, c.carry}
                               << `LCC_COUNT_CARRY);
    wire lcc_word_t rd_gnet = {12'h000, gnet_level, 5'h00, acen_reg,
                               acsel_reg, gdrv_reg, gsrc_reg};
    wire lcc_word_t rd_data =
          ({32{hit_en}}   & rd_en)
        | ({32{hit_dir}}  & rd_dir)
        | ({32{hit_ld}}   & rd_ld)
        | ({32{hit_mem}}  & rd_mem)
        | ({32{hit_ctrl}} & rd_ctrl)
        | ({32{hit_cnt}}  & rd_cnt)
        | ({32{hit_gnet}} & rd_gnet);

    // apb answer: one wait state, data and error with ready
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= '0;
        end
        else
        begin
            pready_reg  <= access;
            pslverr_reg <= access && bad;
            if (access && !PWRITE)
                prdata_reg <= rd_data;
        end
    end

    // software-written configuration
    wire [CW-1:0] wdat = PWDATA[CW-1:0];
    wire [NG-1:0] wsrc = PWDATA[`LCC_GNET_SRC_LSB +: NG];
    wire [NG-1:0] wdrv = PWDATA[`LCC_GNET_DRV_LSB +: NG];
    wire [1:0]    wsel = PWDATA[`LCC_GNET_ACSEL_LSB +: 2];
    wire          wr_ctrl = wr_ok && hit_ctrl;

    wire [CW-1:0] en_next    = (wr_ok && hit_en)  ? wdat : en_reg;
    wire [CW-1:0] dir_next   = (wr_ok && hit_dir) ? wdat : dir_reg;
    wire [CW-1:0] ldata_next = (wr_ok && hit_ld)  ? wdat : ldata_reg;
    wire [CW-1:0] member_next = (wr_ok && hit_mem) ? wdat : member_reg;
    wire casc_next = wr_ctrl ? PWDATA[`LCC_CTRL_CASC] : casc_reg;

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            en_reg     <= CW'(`LCC_ENABLE_RST);
            dir_reg    <= CW'(`LCC_DIR_RST);
            ldata_reg  <= CW'(`LCC_LDATA_RST);
            member_reg <= CW'(`LCC_MEMBER_RST);
            casc_reg   <= 1'b0;
        end
        else
        begin
            en_reg     <= en_next;
            dir_reg    <= dir_next;
            ldata_reg  <= ldata_next;
            member_reg <= member_next;
            casc_reg   <= casc_next;
        end
    end

    wire lcc_word_t gnet_rst = `LCC_GNET_RST;

    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            gsrc_reg  <= gnet_rst[`LCC_GNET_SRC_LSB +: NG];
            gdrv_reg  <= gnet_rst[`LCC_GNET_DRV_LSB +: NG];
            acsel_reg <= gnet_rst[`LCC_GNET_ACSEL_LSB +: 2];
            acen_reg  <= gnet_rst[`LCC_GNET_ACEN];
        end
        else if (wr_ok && hit_gnet)
        begin
            gsrc_reg  <= wsrc;
            gdrv_reg  <= wdrv;
            acsel_reg <= wsel;
            acen_reg  <= PWDATA[`LCC_GNET_ACEN];
        end
    end

    // control pulses last one cycle from the accepted write
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            sclr_pulse_reg  <= 1'b0;
            sload_pulse_reg <= 1'b0;
        end
        else
        begin
            sclr_pulse_reg  <= wr_ctrl && PWDATA[`LCC_CTRL_SCLR];
            sload_pulse_reg <= wr_ctrl && PWDATA[`LCC_CTRL_SLOAD];
        end
    end

    // two flip-flops on every pin before use
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
        end
        else
        begin
            pin_s1_reg <= {CTL_LOAD_IN, CTL_CLR_IN, CASC_IN};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // dedicated nets, also readable as data
    // pin blocked when a cell drives
    lcc_gnet #(.NG(NG)) u_gnet (
        .clk      (CLK),
        .srst     (SRST),
        .pin_raw  (GCTL_PIN),
        .src_cell (gsrc_reg),
        .cell_drv (gdrv_reg),
        .level    (gnet_level)
    );

    // chosen net becomes the async clear
    always_ff @(posedge CLK)
    begin
        if (SRST)
            aclr_reg <= 1'b0;
        else
            aclr_reg <= acen_reg && gnet_level[acsel_reg];
    end

    // control cell inputs make clear and load
    wire sclr_all  = pin_s2_reg[CW] | sclr_pulse_reg;
    wire sload_all = pin_s2_reg[CW+1] | sload_pulse_reg;

    // one clear and one load for all cells
    assign c.sclr    = sclr_all;
    assign c.sload   = sload_all;
    assign c.casc_en = casc_reg;
    assign c.aclr    = aclr_reg;
    assign c.en      = en_reg;
    assign c.dn      = dir_reg;
    assign c.member  = member_reg;
    assign c.ldata   = ldata_reg;
    assign c.casc_in = pin_s2_reg[CW-1:0];

    lcc_cells #(.CW(CW)) u_cells (
        .clk (CLK),
        .srst(SRST),
        .c   (c)
    );

    always_ff @(posedge CLK)
    begin
        if (SRST)
            carry_reg <= 1'b0;
        else
            carry_reg <= c.carry;
    end

    assign PRDATA    = prdata_reg;
    assign PREADY    = pready_reg;
    assign PSLVERR   = pslverr_reg;
    assign COUNT_OUT = c.q;
    assign CARRY_OUT = carry_reg;
    assign GNET_OUT  = gnet_level;

    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);

    apb_wait_a: assert property (access |=> PREADY ##1 !PREADY)
        else $error("apb ready not one cycle after access");
    clear_shared_a: assert property (
        wr_ctrl && PWDATA[`LCC_CTRL_SCLR] |=> c.sclr ##1 c.q == '0)
        else $error("shared clear did not reach all cells");
    pin_clear_a: assert property (
        $rose(CTL_CLR_IN) ##1 CTL_CLR_IN |-> ##1 c.sclr)
        else $error("control cell clear input lost");
    aclr_path_a: assert property (
        acen_reg && gsrc_reg[acsel_reg] && gdrv_reg[acsel_reg]
        && $stable(gsrc_reg) && $stable(gdrv_reg) && $stable(acsel_reg)
        && $stable(acen_reg) |-> ##2 COUNT_OUT == '0)
        else $error("async clear net did not clear count");

    load_write_c: cover property (wr_ctrl && PWDATA[`LCC_CTRL_SLOAD]);
    aclr_c: cover property (aclr_reg && c.q != '0);
endmodule

// ---- lcc_fabric_model.sv ----
// model of the neighbouring cells and fabric that feed the cluster pins
// assumes its tasks are called right after a rising clock edge
module lcc_fabric_model
#(
    parameter int CW = 9
)
(
    // clock
    input wire logic       clk,
    // pins toward the cluster
    output logic           ctl_clr,
    output logic           ctl_load,
    output logic [CW-1:0]  casc,
    output logic [3:0]     gpin
);
    initial
    begin
        ctl_clr  = 1'b0;
        ctl_load = 1'b0;
        casc     = '1;
        gpin     = 4'h0;
    end

    task automatic pulse(input logic clr, input logic load);
        ctl_clr  <= clr;
        ctl_load <= load;
        // held past the two sync flops of the cluster
        repeat (4) @(posedge clk);
        ctl_clr  <= 1'b0;
        ctl_load <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    task automatic set_casc(input logic [CW-1:0] v);
        casc <= v;
        repeat (4) @(posedge clk);
    endtask

    task automatic set_gpin(input logic [3:0] v);
        gpin <= v;
        repeat (4) @(posedge clk);
    endtask
endmodule

// ---- lcc_counter_tb.sv ----
// self-checking bench of the counter cluster: apb, pins, fabric model
// assumes default cell count and a slave with one wait state
`include "lcc_params.svh"

module lcc_counter_tb
    import lcc_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [8:0] member;
        logic [8:0] ld;
        logic [8:0] dir;
        logic [8:0] en;
        logic [8:0] exp;
    } lcc_row_t;

    // en open for exactly three edges between the two enable writes
    lcc_row_t rows [7] = '{
        '{9'h1ff, 9'h000, 9'h000, 9'h1ff, 9'h003},
        '{9'h1ff, 9'h1fe, 9'h000, 9'h1ff, 9'h001},
        '{9'h1ff, 9'h001, 9'h1ff, 9'h1ff, 9'h1fe},
        '{9'h1ff, 9'h0a5, 9'h000, 9'h000, 9'h0a5},
        '{9'h1ff, 9'h001, 9'h000, 9'h1fe, 9'h007},
        '{9'h1ff, 9'h000, 9'h1fe, 9'h1ff, 9'h1ff},
        '{9'h0ff, 9'h1f0, 9'h000, 9'h000, 9'h0f0}};
    lcc_addr_t ra [6] = '{`LCC_ENABLE_OFS, `LCC_DIR_OFS, `LCC_LDATA_OFS,
        `LCC_CTRL_OFS, `LCC_GNET_OFS, `LCC_MEMBER_OFS};
    lcc_word_t rv [6] = '{32'h1ff, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1ff};

    logic        clk;
    logic        srst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    lcc_addr_t   paddr;
    lcc_word_t   pwdata;
    lcc_word_t   prdata;
    logic        pready;
    logic        pslverr;
    logic        ctl_clr;
    logic        ctl_load;
    logic [8:0]  casc;
    logic [3:0]  gpin;
    logic [8:0]  count_out;
    logic        carry_out;
    logic [3:0]  gnet_out;
    lcc_word_t   rdat;
    logic        last_err;
    int          error_cnt;
    int          checks;
    int          cycles;

    lcc_counter lcc_counter_i (.CLK(clk), .SRST(srst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CTL_CLR_IN(ctl_clr), .CTL_LOAD_IN(ctl_load), .CASC_IN(casc),
        .GCTL_PIN(gpin), .COUNT_OUT(count_out), .CARRY_OUT(carry_out),
        .GNET_OUT(gnet_out));

    lcc_fabric_model lcc_fabric_model_i (.clk(clk), .ctl_clr(ctl_clr),
        .ctl_load(ctl_load), .casc(casc), .gpin(gpin));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic wrap_up();
        if (error_cnt == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 4000)
        begin
            error_cnt++;
            wrap_up();
        end
    end

    task automatic chk_word(input string name, input lcc_word_t exp,
                            input lcc_word_t got);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_pin(input string name, input logic [3:0] exp,
                           input logic [3:0] got);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // request held until pready is seen; released only by idle
    task automatic apb(input logic w, input lcc_addr_t a, input lcc_word_t d);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
        begin
            n++;
            if (n == 20)
            begin
                error_cnt++;
                wrap_up();
            end
            @(posedge clk);
        end
        rdat     = prdata;
        last_err = pslverr;
    endtask

    task automatic wr(input lcc_addr_t a, input lcc_word_t d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input lcc_addr_t a);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic idle();
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    initial
    begin
        srst      = 1'b1;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 12'h000;
        pwdata    = 32'h0;
        error_cnt = 0;
        checks    = 0;
        repeat (16) @(posedge clk);
        chk_word("count in reset", 32'h0, {23'h0, count_out});
        srst <= 1'b0;
        @(posedge clk);
        foreach (ra[i])
        begin
            rd(ra[i]);
            chk_word("reset value", rv[i], rdat & 32'h1ff);
        end
        foreach (rows[i])
        begin
            wr(`LCC_MEMBER_OFS, {23'h0, rows[i].member});
            wr(`LCC_ENABLE_OFS, 32'h0);
            wr(`LCC_DIR_OFS, {23'h0, rows[i].dir});
            wr(`LCC_LDATA_OFS, {23'h0, rows[i].ld});
            wr(`LCC_CTRL_OFS, 32'h2);
            wr(`LCC_ENABLE_OFS, {23'h0, rows[i].en});
            wr(`LCC_ENABLE_OFS, 32'h0);
            idle();
            chk_word("row count", {23'h0, rows[i].exp},
                     {23'h0, count_out});
        end
        wr(`LCC_MEMBER_OFS, 32'h1ff);
        wr(`LCC_DIR_OFS, 32'h0);
        wr(`LCC_LDATA_OFS, 32'h1ff);
        wr(`LCC_CTRL_OFS, 32'h2);
        idle();
        idle();
        // carry flop trails the count by one more edge
        idle();
        chk_pin("top carry", 4'h1, {3'h0, carry_out});
        rd(`LCC_COUNT_OFS);
        chk_word("count reg", 32'h8000_01ff, rdat);
        wr(`LCC_LDATA_OFS, 32'h155);
        wr(`LCC_CTRL_OFS, 32'h3);
        idle();
        idle();
        chk_word("clear over load", 32'h0, {23'h0, count_out});
        rd(12'h01c);
        chk_word("unmapped read", 32'h1, {rdat[30:0], last_err});
        wr(`LCC_COUNT_OFS, 32'h5);
        chk_pin("count write", 4'h1, {3'h0, last_err});
        wr(`LCC_LDATA_OFS, 32'h0aa);
        idle();
        lcc_fabric_model_i.pulse(1'b0, 1'b1);
        chk_word("pin load", 32'h0aa, {23'h0, count_out});
        lcc_fabric_model_i.pulse(1'b1, 1'b1);
        chk_word("pin clear", 32'h0, {23'h0, count_out});
        lcc_fabric_model_i.set_casc(9'h0f0);
        wr(`LCC_LDATA_OFS, 32'h1ff);
        wr(`LCC_CTRL_OFS, 32'h6);
        rd(`LCC_CTRL_OFS);
        chk_word("ctrl readback", 32'h4, rdat);
        idle();
        chk_word("cascade", 32'h0f0, {23'h0, count_out});
        wr(`LCC_CTRL_OFS, 32'h5);
        idle();
        idle();
        chk_word("clear over cascade", 32'h0, {23'h0, count_out});
        wr(`LCC_CTRL_OFS, 32'h0);
        idle();
        lcc_fabric_model_i.set_casc(9'h1ff);
        lcc_fabric_model_i.set_gpin(4'h5);
        chk_pin("pin nets", 4'h5, gnet_out);
        wr(`LCC_GNET_OFS, 32'h1);
        idle();
        idle();
        chk_pin("cell net", 4'h4, gnet_out);
        rd(`LCC_GNET_OFS);
        chk_word("net reg", 32'h0004_0001, rdat);
        wr(`LCC_CTRL_OFS, 32'h2);
        wr(`LCC_GNET_OFS, 32'h600);
        wr(`LCC_CTRL_OFS, 32'h2);
        idle();
        idle();
        chk_word("async clear", 32'h0, {23'h0, count_out});
        wr(`LCC_GNET_OFS, 32'h0);
        wr(`LCC_CTRL_OFS, 32'h2);
        // cell drives net 2 and makes it the async clear
        wr(`LCC_GNET_OFS, 32'h644);
        chk_word("load before clear", 32'h1ff, {23'h0, count_out});
        idle();
        idle();
        chk_word("cell async clear", 32'h0, {23'h0, count_out});
        wr(`LCC_GNET_OFS, 32'h0);
        idle();
        wrap_up();
    end
endmodule
